/* hw/mdmio_consts.svh */
/*
  Offsets, field positions, reset values and timing counts of the modem adapter I/O block.
  Assumes it is included by bare name from hw/.
*/
`ifndef MDMIO_CONSTS_SVH
`define MDMIO_CONSTS_SVH

// ----------------------------------------
// Relative port offsets
// ----------------------------------------
`define MDMIO_OFS_SERIAL_STATUS 2'h0
`define MDMIO_OFS_FORMAT_CTRL   2'h0
`define MDMIO_OFS_RX_DATA       2'h1
`define MDMIO_OFS_TX_DATA       2'h1
`define MDMIO_OFS_MODEM_STATUS  2'h2
`define MDMIO_OFS_TIMER_RATE    2'h2
`define MDMIO_OFS_MASK_LOAD     2'h3
`define MDMIO_OFS_LINE_CTRL     2'h3

// ----------------------------------------
// Field positions of the format/modem control register
// ----------------------------------------
`define MDMIO_BIT_ORIGINATE     0
`define MDMIO_BIT_ANSWER        1
`define MDMIO_BIT_CHAR_LEN_LO   2
`define MDMIO_BIT_CHAR_LEN_HI   3
`define MDMIO_BIT_NO_PARITY     4
`define MDMIO_BIT_PARITY_SENSE  5
`define MDMIO_BIT_STOP_COUNT    6
`define MDMIO_BIT_INT_ENABLE    7

// ----------------------------------------
// Modem status fields
// ----------------------------------------
`define MDMIO_BIT_RINGING       1
`define MDMIO_BIT_LINE_HOLD     4
`define MDMIO_BIT_TIMER_PULSE   7

// ----------------------------------------
// Line control fields
// ----------------------------------------
`define MDMIO_BIT_DTR           6

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MDMIO_RESET_BYTE        8'h00
`define MDMIO_LINE_HOLD_S       17
`define MDMIO_CLK_HZ            50000000

`endif

/* hw/mdmio_pkg.sv */
/*
  Types of the modem adapter I/O block.
  Assumes nothing of its surroundings.
*/
package mdmio_pkg;

  typedef enum logic [1:0] {
    DATA5,
    DATA6,
    DATA7,
    DATA8
  } mdmio_len_t;

  typedef enum logic [1:0] {
    LH_IDLE,
    LH_HOLD,
    LH_DONE
  } mdmio_lh_state_t;

endpackage

/* hw/mdmio_fifo.sv */
/*
  Transmit character FIFO, parameterised width and depth.
  Assumes one clock and a synchronised active-low reset.
*/
`timescale 1ns/1ps
module mdmio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstSync_n,
  input  wire logic             clkEn,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWr     = clkEn && inValid && inReady;
  assign doRd     = clkEn && outValid && outReady;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end

  always_ff @(posedge core_clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

/* hw/mdmio_regs.sv */
/*
  Host-visible I/O register bank of a bus-attached FSK modem adapter.
  Assumes bus strobes, address and data are synchronous to core_clk and last one cycle.
*/
// What this block does
// [R1] Character: start, 5-8 data, parity, stops
// [R2] Format set by control bits 2-6
// [R3] Five output registers, mask/line control share address
// [R4] Low control bits, line bits drive modem
// [R5] Bit7 interrupt, 2-6 format, 0-1 modem
// [R6] Software writes whole control byte at once
// [R7] Originate/answer inverted toward modem chip
// [R8] Originate bit selects originate, closes relay
// [R9] Software pulses originate, then clears it
// [R10] Line hold releases after 17 seconds
// [R11] Relay closed by originate or line hold
// [R12] Held originate defeats automatic disconnect
// [R13] Ring status separate from answer bit
// [R14] Answer bit selects answer mode, holds line
// [R15] Software holds bits at least 51 ms
// [R16] Held answer keeps line off hook
// [R17] Length bits decode to 5-8 data bits
// [R18] No-parity bit drops parity bit
// [R19] Rate write; input-3 read loads mask
// [R20] Written one activates its function
// [R21] Parity sense: 0 odd, 1 even
// [R22] Stop bit: 0 one, 1 two/1.5
// [R23] Bit 7 enables bus interrupt requests
// [R24] Software polls buffer empty before writing
// [R25] Length field: bit 2 is LSB
// [R26] Reset clears output registers, sets the two modem lines high
`timescale 1ns/1ps
`include "mdmio_consts.svh"
module mdmio_regs #(
  parameter int  FIFO_DEPTH = 32,
  parameter int  HOLD_CYCLES = `MDMIO_LINE_HOLD_S * `MDMIO_CLK_HZ
) (
  // Clock, reset, enable
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  // Parallel bus I/O cycles
  input  wire logic [1:0] ioAddr,
  input  wire logic       ioWrite,
  input  wire logic       ioRead,
  input  wire logic [7:0] ioWrData,
  output logic [7:0]      ioRdData,
  // Status sources
  input  wire logic [7:0] serialStatus,
  input  wire logic [7:0] rxData,
  input  wire logic [7:0] modemStatusIn,
  input  wire logic       lineHoldIn,
  // Transmit character stream
  output logic            txValid,
  output logic [7:0]      txData,
  input  wire logic       txReady,
  // Modem chip and line
  output logic            originateLine_n,
  output logic            answerLine_n,
  output logic [6:0]      lineControl,
  output logic            auxOut3,
  output logic            lineRelay,
  output logic            lineHold,
  // Serial format and interrupt
  output logic [3:0]      dataBits,
  output logic            parityEnable,
  output logic            parityEven,
  output logic            twoStop,
  output logic            halfStop,
  output logic            intEnable,
  output logic [7:0]      rateDivisor,
  output logic [7:0]      interruptMask
);
  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rstMeta_n;
  logic rstSync_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]                formatCtrl;
    logic [7:0]                rate;
    logic [7:0]                mask;
    logic [7:0]                lineCtrl;
    logic [7:0]                rdData;
    logic [31:0]               holdCount;
    mdmio_pkg::mdmio_lh_state_t lhState;
    logic                      relay;
    logic                      hold;
    logic [3:0]                bits;
    logic                      orgN;
    logic                      ansN;
    logic                      parEn;
    logic                      half;
  } mdmio_state_t;

  mdmio_state_t st;
  mdmio_state_t next_st;

  logic fifoInReady;
  logic fifoInValid;

  function automatic logic [3:0] decodeLen(input logic [1:0] f);
    unique case (mdmio_pkg::mdmio_len_t'(f))
      mdmio_pkg::DATA5: decodeLen = 4'h5;
      mdmio_pkg::DATA6: decodeLen = 4'h6;
      mdmio_pkg::DATA7: decodeLen = 4'h7;
      mdmio_pkg::DATA8: decodeLen = 4'h8;
    endcase
  endfunction

  logic wrCtrl;
  logic wrTx;
  logic wrRate;
  logic wrLine;
  logic rdMask;
  assign wrCtrl = ioWrite && (ioAddr == `MDMIO_OFS_FORMAT_CTRL);
  assign wrTx   = ioWrite && (ioAddr == `MDMIO_OFS_TX_DATA);
  assign wrRate = ioWrite && (ioAddr == `MDMIO_OFS_TIMER_RATE);
  assign wrLine = ioWrite && (ioAddr == `MDMIO_OFS_LINE_CTRL);
  assign rdMask = ioRead && (ioAddr == `MDMIO_OFS_MASK_LOAD);
  // Writes beyond a full FIFO are dropped; software polls empty first
  assign fifoInValid = wrTx; // R24

  always_comb begin
    logic orgBit;
    logic ansBit;
    next_st = st;
    orgBit  = 1'b0;
    ansBit  = 1'b0;
    if (wrCtrl) begin
      next_st.formatCtrl = ioWrData; // R2 R5 R6
    end
    if (wrRate) begin
      next_st.rate = ioWrData; // R19
    end
    if (rdMask) begin
      next_st.mask = st.rate; // R3 R19
    end
    if (wrLine) begin
      next_st.lineCtrl = ioWrData; // R4 R20
    end
    if (ioRead) begin
      unique case (ioAddr)
        `MDMIO_OFS_SERIAL_STATUS: next_st.rdData = serialStatus;
        `MDMIO_OFS_RX_DATA:       next_st.rdData = rxData;
        `MDMIO_OFS_MODEM_STATUS: begin
          // Ringing stays the chip's input, never the answer bit
          next_st.rdData = modemStatusIn; // R13
          next_st.rdData[`MDMIO_BIT_LINE_HOLD] = st.hold; // R10
        end
        `MDMIO_OFS_MASK_LOAD:     next_st.rdData = `MDMIO_RESET_BYTE;
      endcase
    end
    orgBit = st.formatCtrl[`MDMIO_BIT_ORIGINATE];
    ansBit = st.formatCtrl[`MDMIO_BIT_ANSWER];
    // Line hold window opened by lineHoldIn alone, bounded in time
    unique case (st.lhState)
      mdmio_pkg::LH_IDLE: begin
        if (lineHoldIn) begin
          next_st.lhState   = mdmio_pkg::LH_HOLD;
          next_st.holdCount = '0;
        end
      end
      mdmio_pkg::LH_HOLD: begin
        if (!lineHoldIn) begin
          next_st.lhState = mdmio_pkg::LH_IDLE;
        end else if (st.holdCount == 32'(HOLD_CYCLES - 1)) begin
          next_st.lhState = mdmio_pkg::LH_DONE; // R10
        end else begin
          next_st.holdCount = st.holdCount + 32'h0000_0001;
        end
      end
      mdmio_pkg::LH_DONE: begin
        if (!lineHoldIn) begin
          next_st.lhState = mdmio_pkg::LH_IDLE;
        end
      end
    endcase
    next_st.hold  = lineHoldIn && (next_st.lhState == mdmio_pkg::LH_HOLD);
    // Control bits in parallel with line hold; held bit defeats disconnect
    next_st.relay = orgBit || ansBit || next_st.hold; // R8 R11 R12 R14 R16
    next_st.bits  = decodeLen(st.formatCtrl[3:2]); // R17 R25 R1
    // Outputs leave straight from flip-flops, so derive them from the next value
    next_st.orgN  = ~next_st.formatCtrl[`MDMIO_BIT_ORIGINATE]; // R7
    next_st.ansN  = ~next_st.formatCtrl[`MDMIO_BIT_ANSWER]; // R7
    next_st.parEn = ~next_st.formatCtrl[`MDMIO_BIT_NO_PARITY]; // R18
    next_st.half  = next_st.formatCtrl[`MDMIO_BIT_STOP_COUNT]
                    && (next_st.formatCtrl[3:2] == 2'b00); // R22
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st      <= '0; // R26
      // Modem control lines idle high, so the line stays released
      st.orgN <= 1'b1;
      st.ansN <= 1'b1;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic txValidQ;
  logic [7:0] txDataQ;
  logic takeOut;
  assign takeOut = fifoOutValid && (!txValidQ || txReady);

  mdmio_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rstSync_n (rstSync_n),
    .clkEn     (clkEn),
    .inValid   (fifoInValid),
    .inData    (ioWrData),
    .inReady   (fifoInReady),
    .outValid  (fifoOutValid),
    .outData   (fifoOutData),
    .outReady  (takeOut)
  );

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txValidQ <= 1'b0;
      txDataQ  <= 8'h00;
    end else if (clkEn) begin
      if (takeOut) begin
        txValidQ <= 1'b1;
        txDataQ  <= fifoOutData;
      end else if (txReady) begin
        txValidQ <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign txValid         = txValidQ;
  assign txData          = txDataQ;
  assign ioRdData        = st.rdData;
  assign originateLine_n = st.orgN; // R7 R9
  assign answerLine_n    = st.ansN; // R7 R15
  assign lineControl     = st.lineCtrl[6:0]; // R4 R20
  assign auxOut3         = st.lineCtrl[7];
  assign lineRelay       = st.relay;
  assign lineHold        = st.hold;
  assign dataBits        = st.bits;
  assign parityEnable    = st.parEn; // R18
  assign parityEven      = st.formatCtrl[`MDMIO_BIT_PARITY_SENSE]; // R21
  assign twoStop         = st.formatCtrl[`MDMIO_BIT_STOP_COUNT]; // R22
  assign halfStop        = st.half; // R22
  assign intEnable       = st.formatCtrl[`MDMIO_BIT_INT_ENABLE]; // R23
  assign rateDivisor     = st.rate;
  assign interruptMask   = st.mask;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_ctrl_write;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrCtrl) |=> (intEnable == $past(ioWrData[7]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // R5

  property p_invert;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrCtrl) |=> (originateLine_n == !$past(ioWrData[0]))
                         && (answerLine_n == !$past(ioWrData[1]));
  endproperty
  a_invert: assert property (p_invert) else $error("control lines not inverted"); // R7

  property p_mask_load;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && rdMask && !wrRate) |=> (interruptMask == $past(rateDivisor));
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask not loaded from rate"); // R19

  property p_relay;
    @(posedge core_clk) disable iff (!rstSync_n)
      clkEn && $past(clkEn) && (!originateLine_n || !answerLine_n) |=> lineRelay;
  endproperty
  a_relay: assert property (p_relay) else $error("relay open with control set"); // R11

  property p_len;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrCtrl && ioWrData[3:2] == 2'b11) ##1 clkEn |=> (dataBits == 4'h8);
  endproperty
  a_len: assert property (p_len) else $error("length decode wrong"); // R17

  property p_parity;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrCtrl) |=> (parityEnable != $past(ioWrData[4]));
  endproperty
  a_parity: assert property (p_parity) else $error("no parity bit wrong"); // R18

  property p_line_ctrl;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrLine) |=> (lineControl[6] == $past(ioWrData[6]));
  endproperty
  a_line_ctrl: assert property (p_line_ctrl) else $error("DTR not driven"); // R20

  property p_hold_bound;
    @(posedge core_clk) disable iff (!rstSync_n)
      st.holdCount <= 32'(HOLD_CYCLES);
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("line hold overran"); // R10

  property p_parity_sense;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrCtrl) |=> (parityEven == $past(ioWrData[5]));
  endproperty
  a_parity_sense: assert property (p_parity_sense) else $error("parity sense wrong"); // R21

  property p_stop;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrCtrl) |=> (twoStop == $past(ioWrData[6]))
        && (halfStop == ($past(ioWrData[6]) && ($past(ioWrData[3:2]) == 2'b00)));
  endproperty
  a_stop: assert property (p_stop) else $error("stop count wrong"); // R22

  property p_len_all;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrCtrl) ##1 (clkEn && !wrCtrl)
        |=> (dataBits == 4'h5 + 4'($past(ioWrData[3:2], 2)));
  endproperty
  a_len_all: assert property (p_len_all) else $error("length field order wrong"); // R25

  property p_rate_write;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrRate) |=> (rateDivisor == $past(ioWrData));
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate write lost"); // R19

  property p_mask_hold;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && !rdMask) |=> (interruptMask == $past(interruptMask));
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without load"); // R3

  property p_line_aux;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && wrLine) |=> (lineControl == $past(ioWrData[6:0]))
        && (auxOut3 == $past(ioWrData[7]));
  endproperty
  a_line_aux: assert property (p_line_aux) else $error("line control byte lost"); // R4

  property p_status_read;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && ioRead && ioAddr == `MDMIO_OFS_MODEM_STATUS)
        |=> (ioRdData[1] == $past(modemStatusIn[1])) && (ioRdData[4] == $past(lineHold));
  endproperty
  a_status_read: assert property (p_status_read) else $error("modem status wrong"); // R13 R10

  property p_relay_follow;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && originateLine_n && answerLine_n) |=> (lineRelay == lineHold);
  endproperty
  a_relay_follow: assert property (p_relay_follow) else $error("relay not from line hold"); // R11

  property p_hold_drop;
    @(posedge core_clk) disable iff (!rstSync_n)
      (clkEn && !lineHoldIn) |=> !lineHold;
  endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("line hold outlived modem"); // R10

  c_dial:   cover property (@(posedge core_clk) disable iff (!rstSync_n) wrCtrl && ioWrData[0]);
  c_answer: cover property (@(posedge core_clk) disable iff (!rstSync_n) lineRelay && !answerLine_n);
  c_mask:   cover property (@(posedge core_clk) disable iff (!rstSync_n) rdMask);
  c_full:   cover property (@(posedge core_clk) disable iff (!rstSync_n) !fifoInReady);
  c_expire: cover property (@(posedge core_clk) disable iff (!rstSync_n) lineHoldIn && !lineHold);
endmodule

/* verification/mdmio_modem_model.sv */
/*
  Model of the serial engine that drains the transmit character stream.
  Assumes the bench drives stall just after a rising clock edge.
*/
`timescale 1ns/1ps
module mdmio_modem_model (
  // Clock and stall control
  input  wire logic       core_clk,
  input  wire logic       stall,
  // Transmit stream
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady
);
  logic [7:0] got[$];

  // Busy engine refuses characters while stalled
  assign txReady = !stall;

  always @(posedge core_clk) begin
    if (txValid && txReady) begin
      got.push_back(txData);
    end
  end
endmodule

/* verification/modem_adapter_io_registers_bench.sv */
/*
  Self-checking bench of the modem adapter I/O register bank.
  Assumes a shortened line-hold count and the modem model beside the block.
*/
`timescale 1ns/1ps
module modem_adapter_io_registers_bench;
  logic       core_clk, rst_n, clkEn, ioWrite, ioRead, lineHoldIn, stall, txValid, txReady;
  logic       originateLine_n, answerLine_n, auxOut3, lineRelay, lineHold, intEnable;
  logic       parityEnable, parityEven, twoStop, halfStop;
  logic [1:0] ioAddr;
  logic [3:0] dataBits;
  logic [6:0] lineControl;
  logic [7:0] ioWrData, ioRdData, serialStatus, rxData, modemStatusIn, txData;
  logic [7:0] rateDivisor, interruptMask, v;
  int         failCount, compares, cyc;

  // ----------------------------------------
  // Clock, block and modem model
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  mdmio_regs #(.FIFO_DEPTH(32), .HOLD_CYCLES(50)) dut (
    .core_clk, .rst_n, .clkEn, .ioAddr, .ioWrite, .ioRead, .ioWrData, .ioRdData,
    .serialStatus, .rxData, .modemStatusIn, .lineHoldIn, .txValid, .txData, .txReady,
    .originateLine_n, .answerLine_n, .lineControl, .auxOut3, .lineRelay, .lineHold,
    .dataBits, .parityEnable, .parityEven, .twoStop, .halfStop, .intEnable,
    .rateDivisor, .interruptMask
  );

  mdmio_modem_model model (.core_clk, .stall, .txValid, .txData, .txReady);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    ioAddr = a;
    ioWrData = d;
    ioWrite = 1'b1;
    tick(1);
    ioWrite = 1'b0;
    tick(2);
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    ioAddr = a;
    ioRead = 1'b1;
    tick(1);
    ioRead = 0;
    tick(1);
    d = ioRdData;
  endtask

  task automatic printVerdict();
    $display("checks %0d errors %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("orig_n", originateLine_n, 8'h01);
    chk("ans_n", answerLine_n, 8'h01);
    chk("int", intEnable, 8'h00);
    chk("relay", lineRelay, 8'h00);
    chk("linectl", lineControl, 8'h00);
    chk("rate", rateDivisor, 8'h00);
  endtask

  task automatic t_format();
    for (int i = 0; i < 32; i++) begin
      wr(2'h0, 8'(i << 2));
      chk("bits", dataBits, 8'(5 + i % 4));
      chk("par", parityEnable, 8'(!i[2]));
      if (!i[2]) chk("even", parityEven, 8'(i[3]));
      chk("two", twoStop, 8'(i[4]));
      chk("half", halfStop, 8'(i[4] && i % 4 == 0));
      chk("relay", lineRelay, 8'h00);
    end
  endtask

  task automatic t_lines();
    wr(2'h0, 8'h81);
    chk("int", intEnable, 8'h01);
    chk("orig_n", originateLine_n, 8'h00);
    chk("relay", lineRelay, 8'h01);
    // Whole byte replaced: interrupt and originate drop together
    wr(2'h0, 8'h02);
    chk("int", intEnable, 8'h00);
    chk("orig_n", originateLine_n, 8'h01);
    chk("ans_n", answerLine_n, 8'h00);
    chk("relay", lineRelay, 8'h01);
    wr(2'h0, 8'h00);
    chk("relay", lineRelay, 8'h00);
  endtask

  task automatic t_hold();
    modemStatusIn = 8'h02;
    rd(2'h2, v);
    chk("ring", v, 8'h02);
    chk("ans_n", answerLine_n, 8'h01);
    modemStatusIn = 8'h00;
    lineHoldIn = 1'b1;
    tick(3);
    chk("hold", lineHold, 8'h01);
    chk("relay", lineRelay, 8'h01);
    rd(2'h2, v);
    chk("status", v, 8'h10);
    tick(60);
    chk("hold", lineHold, 8'h00);
    chk("relay", lineRelay, 8'h00);
    wr(2'h0, 8'h01);
    chk("relay", lineRelay, 8'h01);
    wr(2'h0, 8'h00);
    lineHoldIn = 1'b0;
  endtask

  task automatic t_rate();
    wr(2'h2, 8'hA5);
    chk("rate", rateDivisor, 8'hA5);
    rd(2'h3, v);
    chk("rd3", v, 8'h00);
    chk("mask", interruptMask, 8'hA5);
    wr(2'h2, 8'h34);
    chk("rate", rateDivisor, 8'h34);
    chk("mask", interruptMask, 8'hA5);
    wr(2'h3, 8'hC0);
    chk("linectl", lineControl, 8'h40);
    chk("aux3", auxOut3, 8'h01);
    wr(2'h3, 8'h3F);
    chk("linectl", lineControl, 8'h3F);
    chk("aux3", auxOut3, 8'h00);
    serialStatus = 8'h5A;
    rxData = 8'hC3;
    rd(2'h0, v);
    chk("serstat", v, 8'h5A);
    rd(2'h1, v);
    chk("rxdata", v, 8'hC3);
  endtask

  task automatic t_freeze();
    clkEn = 1'b0;
    wr(2'h0, 8'h81);
    wr(2'h1, 8'hEE);
    chk("int", intEnable, 8'h00);
    chk("orig_n", originateLine_n, 8'h01);
    clkEn = 1'b1;
    wr(2'h0, 8'h81);
    chk("int", intEnable, 8'h01);
    // Second reset in mid-run clears the output registers and sets orig_n high
    rst_n = 1'b0;
    tick(2);
    chk("int", intEnable, 8'h00);
    chk("orig_n", originateLine_n, 8'h01);
    chk("relay", lineRelay, 8'h00);
    chk("rate", rateDivisor, 8'h00);
    chk("mask", interruptMask, 8'h00);
    chk("linectl", lineControl, 8'h00);
    rst_n = 1'b1;
    tick(3);
  endtask

  task automatic t_fifo();
    stall = 1'b1;
    // Output stage plus 32 FIFO words take 33; the 34th is dropped
    for (int i = 0; i < 34; i++) wr(2'h1, 8'(8'h40 + i));
    chk("early", 8'(model.got.size()), 8'h00);
    stall = 1'b0;
    tick(45);
    chk("count", 8'(model.got.size()), 8'h21);
    foreach (model.got[i]) chk("txbyte", model.got[i], 8'(8'h40 + i));
    chk("txvalid", txValid, 8'h00);
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      failCount++;
      printVerdict();
    end
  end

  initial begin
    {rst_n, ioWrite, ioRead, lineHoldIn, stall, ioAddr} = '0;
    clkEn = 1'b1;
    {ioWrData, serialStatus, rxData, modemStatusIn} = '0;
    repeat (10) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    // Reset synchroniser needs two edges before the first request
    tick(3);
    t_reset();
    t_format();
    t_lines();
    t_hold();
    t_rate();
    t_freeze();
    t_fifo();
    printVerdict();
  end
endmodule
